// ---- ccl_codec_ctrl.sv ----
/*
 * Codec configuration: serial control port decoder, control register,
 * interface latches and transmit/receive time-slot assignment with
 * PCM shifting and loopback.
 * Assumes cclk, bclk and frame syncs are sampled levels synchronous to
 * clk_i, each high or low for at least two clk_i cycles.
 */
`timescale 1ns/10ps
`include "ccl_consts.svh"

// Function
// [RL1] Control bits 7:6 choose master clock divider 512k, 1.5M, 2.048M, 4.096M.
// [RL2] Bit 5 clear mu-law; set with bit 4 clear A-law inverted; both set plain.
// [RL3] Bit 3 zero delayed, one non-delayed; slot assignment only when delayed.
// [RL4] After reset timing is non-delayed; slot begins at frame sync rise.
// [RL5] Bits 2:1 mode: 00 normal, 1x digital loop, 01 analog loop.
// [RL6] Analog loop feeds transmit input from receive output, gains unchanged.
// [RL7] Digital loop sends receive PCM register in the transmit slot.
// [RL8] In either loop receive decoding keeps driving the analog output.
// [RL9] Bit 0 zero keeps amp on in power-down, one disables it.
// [RL10] Host disables hybrid balance before using analog loopback.
// [RL11] After reset all latches are inputs, pins undriven.
// [RL12] Direction byte bits 7:2 map latches 0..5; one means output.
// [RL13] Host programs unused latches, and latch 5 on small variant, as outputs.
// [RL14] Output latches drive content bits 7:2 for latches 0..5.
// [RL15] Content readback gives pin level for inputs, written level for outputs.
// [RL16] Host writes latch levels first, then direction, at initialisation.
// [RL17] Frame sync marks slot 0; counters count 8-bit slots, up to 64.
// [RL18] Low six assignment bits are slot 0..63, bit 5 most significant.
// [RL19] New assignment takes effect on second frame after chip select release.
// [RL20] Assignment bit 7 clear disables port; bit 6 picks port 0 or 1.
// [RL21] PCM words shift most significant bit first.
// [RL22] Full-scale and zero codes per law follow the coding tables.
// [RL23] Two-byte writes load the target register at the eighth falling clock.
// [RL24] Transmit shifts on rising bit clock, receive samples on falling edge.
module ccl_codec_ctrl
    import ccl_pkg::*;
#(
    parameter int NUM_LATCH = 6,
    parameter int SLOTS = 64
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cclk_i,
    input wire logic cs_n_i,
    input wire logic ctl_data_i,
    output logic ctl_data_o,
    output logic ctl_data_oe_o,
    input wire logic bclk_i,
    input wire logic tx_frame_sync_i,
    input wire logic rx_frame_sync_i,
    input wire logic rx_pcm_port0_i,
    input wire logic rx_pcm_port1_i,
    output logic tx_pcm_port0_o,
    output logic tx_pcm_port0_oe_o,
    output logic tx_pcm_port1_o,
    output logic tx_pcm_port1_oe_o,
    input wire logic [7:0] tx_codec_word_i,
    output logic [7:0] rx_codec_word_o,
    output logic rx_word_valid_o,
    output logic analog_loop_o,
    output logic tx_input_from_rx_o,
    output logic rx_decode_run_o,
    output logic [1:0] mclk_sel_o,
    output logic [1:0] law_o,
    output logic powered_down_state_o,
    output logic amp_off_o,
    input wire logic [NUM_LATCH-1:0] latch_pin_i,
    output logic [NUM_LATCH-1:0] latch_pin_o,
    output logic [NUM_LATCH-1:0] latch_pin_oe_o
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] ctrl_reg;
    logic [7:0] ldir_reg;
    logic [7:0] lcont_reg;
    logic [7:0] txts_reg, rxts_reg;
    logic [7:0] txts_act_reg, rxts_act_reg;
    logic [1:0] txts_pend_reg, rxts_pend_reg;
    logic pwr_dn_reg;
    logic cclk_d_reg, bclk_d_reg, fsx_d_reg, fsr_d_reg, cs_d_reg;
    logic [7:0] sh_reg;
    logic [2:0] bcnt_reg;
    logic byte2_reg;
    logic [7:0] b1_reg;
    logic [7:0] rd_reg;
    logic ctl_oe_reg, ctl_do_reg;
    logic [7:0] txsh_reg, rxsh_reg, rxpcm_reg;
    logic tx0_reg, tx0oe_reg, tx1_reg, tx1oe_reg;
    logic rxv_reg;
    logic [NUM_LATCH-1:0] lpin_reg, loe_reg;
    logic [1:0] fsx_since_up_reg;

    ////////////////////////////////////////////////////////////////////////
    // Edge strobes; inputs already synchronous
    wire logic cclk_fall = cclk_d_reg && !cclk_i;
    wire logic cclk_rise = !cclk_d_reg && cclk_i;
    wire logic bclk_rise = !bclk_d_reg && bclk_i;
    wire logic bclk_fall = bclk_d_reg && !bclk_i;
    wire logic fsx_rise = !fsx_d_reg && tx_frame_sync_i;
    wire logic fsr_rise = !fsr_d_reg && rx_frame_sync_i;
    wire logic cs_release = !cs_d_reg && cs_n_i;
    wire logic byte_done = cclk_fall && !cs_n_i && (bcnt_reg == 3'h7);
    wire logic [7:0] byte_in = {sh_reg[6:0], ctl_data_i};
    wire logic [3:0] addr = b1_reg[6:3];
    wire logic is_wr = byte_done && byte2_reg && !b1_reg[`CCL_B1_RD];

    // Control field decoding
    wire logic tsa_mode = !ctrl_reg[`CCL_CTL_TIMING]; // see [RL3]
    wire logic dloop = ctrl_reg[`CCL_CTL_DLOOP]; // see [RL5]
    wire logic aloop = !ctrl_reg[`CCL_CTL_DLOOP] && ctrl_reg[`CCL_CTL_ALOOP]; // see [RL5]
    // Map byte bits 7..2 to latch 0..5 (MSB side is latch 0)
    function automatic logic [NUM_LATCH-1:0] to_latch(input logic [7:0] b);
        logic [NUM_LATCH-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_LATCH; i++) begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction : to_latch

    function automatic logic [7:0] from_latch(input logic [NUM_LATCH-1:0] l);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < NUM_LATCH; i++) begin
            r[7 - i] = l[i];
        end
        return r;
    endfunction : from_latch

    // Law decoding, bit 4 ignored under mu-law
    function automatic logic [1:0] law_of(input logic [7:0] c);
        ccl_law_t l;
        l = !c[`CCL_CTL_LAW] ? CCL_LAW_MU : (c[`CCL_CTL_INV] ? CCL_LAW_A_PLAIN : CCL_LAW_A_INV);
        return l;
    endfunction : law_of

    wire logic [NUM_LATCH-1:0] lat_dir = to_latch(ldir_reg);
    wire logic [NUM_LATCH-1:0] lat_lvl = to_latch(lcont_reg);
    // Readback mixes sensed inputs and programmed outputs
    wire logic [NUM_LATCH-1:0] lat_rd = (lat_dir & lat_lvl) | (~lat_dir & latch_pin_i); // see [RL15]
    wire logic [7:0] rd_mux =
        (addr == `CCL_ADDR_CTRL) ? ctrl_reg :
        (addr == `CCL_ADDR_LDIR) ? ldir_reg :
        (addr == `CCL_ADDR_LCONT) ? from_latch(lat_rd) :
        (addr == `CCL_ADDR_TXTS) ? txts_reg :
        (addr == `CCL_ADDR_RXTS) ? rxts_reg : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Edge history
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cclk_d_reg <= 1'b0;
            bclk_d_reg <= 1'b0;
            fsx_d_reg <= 1'b0;
            fsr_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else begin
            cclk_d_reg <= cclk_i;
            bclk_d_reg <= bclk_i;
            fsx_d_reg <= tx_frame_sync_i;
            fsr_d_reg <= rx_frame_sync_i;
            cs_d_reg <= cs_n_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial control port: shift in on falling cclk, MSB first
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sh_reg <= 8'h00;
            bcnt_reg <= 3'h0;
            byte2_reg <= 1'b0;
            b1_reg <= 8'h00;
            pwr_dn_reg <= 1'b1;
        end else if (cs_n_i) begin
            bcnt_reg <= 3'h0;
        end else if (cclk_fall) begin
            sh_reg <= byte_in;
            bcnt_reg <= bcnt_reg + 3'h1;
            if (bcnt_reg == 3'h7) begin
                if (!byte2_reg) begin
                    b1_reg <= byte_in;
                    pwr_dn_reg <= byte_in[`CCL_B1_PWR];
                    byte2_reg <= byte_in[`CCL_B1_TWO];
                end else begin
                    byte2_reg <= 1'b0;
                end
            end
        end
    end

    // Register loads at eighth falling clock of byte 2
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl_reg <= `CCL_CTRL_RST; // see [RL4]
            ldir_reg <= `CCL_LDIR_RST; // see [RL11]
            lcont_reg <= `CCL_LCONT_RST;
            txts_reg <= `CCL_TS_RST;
            rxts_reg <= `CCL_TS_RST;
        end else if (is_wr) begin // see [RL23]
            ctrl_reg <= (addr == `CCL_ADDR_CTRL) ? byte_in : ctrl_reg;
            ldir_reg <= (addr == `CCL_ADDR_LDIR) ? {byte_in[7:2], 2'b00} : ldir_reg; // see [RL12]
            lcont_reg <= (addr == `CCL_ADDR_LCONT) ? {byte_in[7:2], 2'b00} : lcont_reg;
            txts_reg <= (addr == `CCL_ADDR_TXTS) ? byte_in : txts_reg;
            rxts_reg <= (addr == `CCL_ADDR_RXTS) ? byte_in : rxts_reg;
        end
    end

    // Readback: clear on first byte done, load at first rising cclk of byte 2, then shift out on rising cclk
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rd_reg <= 8'h00;
            ctl_oe_reg <= 1'b0;
            ctl_do_reg <= 1'b0;
        end else if (cs_n_i) begin
            ctl_oe_reg <= 1'b0; // Undriven while deselected
        end else if (byte_done && !byte2_reg && byte_in[`CCL_B1_RD]) begin
            rd_reg <= 8'h00;
            ctl_oe_reg <= 1'b0;
        end else if (byte2_reg && b1_reg[`CCL_B1_RD] && cclk_rise) begin
            ctl_do_reg <= (bcnt_reg == 3'h0) ? rd_mux[7] : rd_reg[7];
            rd_reg <= (bcnt_reg == 3'h0) ? {rd_mux[6:0], 1'b0} : {rd_reg[6:0], 1'b0};
            ctl_oe_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assignment activation: second frame after chip select release
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            txts_pend_reg <= 2'h0;
            rxts_pend_reg <= 2'h0;
            txts_act_reg <= `CCL_TS_RST;
            rxts_act_reg <= `CCL_TS_RST;
        end else begin
            if (cs_release && b1_reg[6:3] == `CCL_ADDR_TXTS && !b1_reg[`CCL_B1_RD]) begin
                txts_pend_reg <= 2'h2;
            end else if (fsx_rise && txts_pend_reg != 2'h0) begin // see [RL19]
                txts_pend_reg <= txts_pend_reg - 2'h1;
                if (txts_pend_reg == 2'h1) txts_act_reg <= txts_reg;
            end
            if (cs_release && b1_reg[6:3] == `CCL_ADDR_RXTS && !b1_reg[`CCL_B1_RD]) begin
                rxts_pend_reg <= 2'h2;
            end else if (fsr_rise && rxts_pend_reg != 2'h0) begin // see [RL19]
                rxts_pend_reg <= rxts_pend_reg - 2'h1;
                if (rxts_pend_reg == 2'h1) rxts_act_reg <= rxts_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot location per direction
    logic tx_in_slot, rx_in_slot;
    logic [2:0] tx_bit, rx_bit;

    ccl_slot_ctr #(.SLOTS(SLOTS)) u_tx_slot (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .bit_tick_i(bclk_fall),
        .fs_start_i(fsx_rise),
        .slot_i(txts_act_reg[5:0]), // see [RL18]
        .tsa_mode_i(tsa_mode),
        .in_slot_o(tx_in_slot),
        .bit_idx_o(tx_bit)
    );

    ccl_slot_ctr #(.SLOTS(SLOTS)) u_rx_slot (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .bit_tick_i(bclk_fall),
        .fs_start_i(fsr_rise),
        .slot_i(rxts_act_reg[5:0]), // see [RL18]
        .tsa_mode_i(tsa_mode),
        .in_slot_o(rx_in_slot),
        .bit_idx_o(rx_bit)
    );

    // Port enables; outputs wait for second frame sync after power-up
    wire logic tx_en = txts_act_reg[`CCL_TS_EN] && !pwr_dn_reg && (fsx_since_up_reg == 2'h2);
    wire logic tx_p1 = txts_act_reg[`CCL_TS_PORT]; // see [RL20]
    wire logic rx_en = rxts_act_reg[`CCL_TS_EN];
    wire logic rx_bit_in = rxts_act_reg[`CCL_TS_PORT] ? rx_pcm_port1_i : rx_pcm_port0_i;
    wire logic [7:0] tx_word = dloop ? rxpcm_reg : tx_codec_word_i; // see [RL7]

    ////////////////////////////////////////////////////////////////////////
    // Transmit: shift out MSB first on rising bclk
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            txsh_reg <= 8'h00;
            tx0_reg <= 1'b0;
            tx1_reg <= 1'b0;
            tx0oe_reg <= 1'b0;
            tx1oe_reg <= 1'b0;
            fsx_since_up_reg <= 2'h0;
        end else begin
            if (pwr_dn_reg) fsx_since_up_reg <= 2'h0;
            else if (fsx_rise && fsx_since_up_reg != 2'h2) fsx_since_up_reg <= fsx_since_up_reg + 2'h1;
            if (bclk_rise) begin // see [RL24]
                if (tx_in_slot && tx_en) begin
                    txsh_reg <= (tx_bit == 3'h0) ? {tx_word[6:0], 1'b0} : {txsh_reg[6:0], 1'b0};
                    tx0_reg <= (tx_bit == 3'h0) ? tx_word[7] : txsh_reg[7]; // see [RL21]
                    tx1_reg <= (tx_bit == 3'h0) ? tx_word[7] : txsh_reg[7];
                    tx0oe_reg <= !tx_p1; // see [RL20]
                    tx1oe_reg <= tx_p1;
                end else begin
                    tx0oe_reg <= 1'b0;
                    tx1oe_reg <= 1'b0;
                end
            end
        end
    end

    // Receive: sample on falling bclk, word to decoder at slot end
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rxsh_reg <= 8'h00;
            rxpcm_reg <= 8'h00;
            rxv_reg <= 1'b0;
        end else begin
            rxv_reg <= 1'b0;
            if (bclk_fall && rx_in_slot && rx_en) begin // see [RL24]
                rxsh_reg <= {rxsh_reg[6:0], rx_bit_in}; // see [RL21]
                if (rx_bit == 3'h7) begin
                    rxpcm_reg <= {rxsh_reg[6:0], rx_bit_in};
                    rxv_reg <= 1'b1; // see [RL8]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latch pins: outputs drive content bits
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            lpin_reg <= '0;
            loe_reg <= '0; // see [RL11]
        end else begin
            lpin_reg <= lat_lvl; // see [RL14]
            loe_reg <= lat_dir;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output assignments, all from flip-flops
    assign ctl_data_o = ctl_do_reg;
    assign ctl_data_oe_o = ctl_oe_reg;
    assign tx_pcm_port0_o = tx0_reg;
    assign tx_pcm_port0_oe_o = tx0oe_reg;
    assign tx_pcm_port1_o = tx1_reg;
    assign tx_pcm_port1_oe_o = tx1oe_reg;
    assign rx_codec_word_o = rxpcm_reg;
    assign rx_word_valid_o = rxv_reg;
    assign mclk_sel_o = ctrl_reg[`CCL_CTL_DIV_HI:`CCL_CTL_DIV_LO]; // see [RL1]
    assign powered_down_state_o = pwr_dn_reg;

    // Decoded status registered so no pin glitches on a control write
    always_ff @(posedge clk_i) begin
        analog_loop_o <= aloop; // see [RL6]
        tx_input_from_rx_o <= aloop; // see [RL6]
        rx_decode_run_o <= !pwr_dn_reg; // Loops never stop decoding, see [RL8]
        law_o <= law_of(ctrl_reg); // Sets the code tables, see [RL2] [RL22]
        amp_off_o <= pwr_dn_reg && ctrl_reg[`CCL_CTL_AMP]; // see [RL9]
    end
    assign latch_pin_o = lpin_reg;
    assign latch_pin_oe_o = loe_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_LATCH_RESET_IN: assert property (@(posedge clk_i) // see [RL11]
        !resetn_i |=> latch_pin_oe_o == '0)
        else $error("latch drove after reset");
    AST_LATCH_DRIVE: assert property (@(posedge clk_i) disable iff (!resetn_i) // see [RL14]
        ##1 latch_pin_oe_o == $past(lat_dir) && latch_pin_o == $past(lat_lvl))
        else $error("latch pin mismatch");
    AST_LDIR_LOW_IGNORED: assert property (@(posedge clk_i) disable iff (!resetn_i) // see [RL12]
        ldir_reg[1:0] == 2'b00)
        else $error("direction low bits stored");
    AST_TIMING_RESET: assert property (@(posedge clk_i) // see [RL4]
        !resetn_i |=> ctrl_reg == `CCL_CTRL_RST && !tsa_mode)
        else $error("reset timing not non-delayed");
    AST_AMP: assert property (@(posedge clk_i) disable iff (!resetn_i) // see [RL9]
        1'b1 |=> amp_off_o == $past(pwr_dn_reg && ctrl_reg[0]))
        else $error("amp control wrong");
    AST_LAW_MU: assert property (@(posedge clk_i) disable iff (!resetn_i) // see [RL2]
        !ctrl_reg[5] |=> law_o == 2'(CCL_LAW_MU))
        else $error("law not mu");
    AST_MODE: assert property (@(posedge clk_i) disable iff (!resetn_i) // see [RL5]
        ctrl_reg[2] |=> !analog_loop_o)
        else $error("digital loop overridden");
    AST_CTRL_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i) // see [RL23]
        is_wr && addr == `CCL_ADDR_CTRL |=> ctrl_reg == $past(byte_in))
        else $error("control write lost");
    AST_TX_ONE_PORT: assert property (@(posedge clk_i) disable iff (!resetn_i) // see [RL20]
        !(tx_pcm_port0_oe_o && tx_pcm_port1_oe_o))
        else $error("both transmit ports on");
endmodule : ccl_codec_ctrl

// ---- ccl_consts.svh ----
/*
 * Constants for the codec control, latch and time-slot block:
 * instruction codes, control field positions, reset values.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef CCL_CONSTS_SVH
`define CCL_CONSTS_SVH

// Byte 1 register address field (bits 6..3)
`define CCL_ADDR_CTRL 4'h0
`define CCL_ADDR_LDIR 4'h2
`define CCL_ADDR_LCONT 4'h1
`define CCL_ADDR_TXTS 4'hA
`define CCL_ADDR_RXTS 4'h9
// Byte 1 bit positions
`define CCL_B1_PWR 7
`define CCL_B1_RD 2
`define CCL_B1_TWO 1
// Control register fields
`define CCL_CTL_DIV_HI 7
`define CCL_CTL_DIV_LO 6
`define CCL_CTL_LAW 5
`define CCL_CTL_INV 4
`define CCL_CTL_TIMING 3
`define CCL_CTL_DLOOP 2
`define CCL_CTL_ALOOP 1
`define CCL_CTL_AMP 0
// Assignment fields
`define CCL_TS_EN 7
`define CCL_TS_PORT 6
// Reset values: non-delayed timing, mu-law, normal mode
`define CCL_CTRL_RST 8'h08
`define CCL_LDIR_RST 8'h00
`define CCL_LCONT_RST 8'h00
`define CCL_TS_RST 8'h00
// Slot geometry and latch count
`define CCL_SLOT_BITS 8
`define CCL_NUM_LATCH 6

`endif

// ---- ccl_pkg.sv ----
/*
 * Types for the codec control, latch and time-slot block.
 * Assumes ccl_consts.svh is available on the include path.
 */
package ccl_pkg;
    `include "ccl_consts.svh"
    typedef enum logic [1:0] {CCL_MCLK_512K, CCL_MCLK_1536K, CCL_MCLK_2048K,
        CCL_MCLK_4096K} ccl_mclk_t;
    typedef enum logic [1:0] {CCL_LAW_MU, CCL_LAW_A_INV, CCL_LAW_A_PLAIN} ccl_law_t;
    typedef enum logic [1:0] {CCL_MODE_NORMAL, CCL_MODE_DLOOP, CCL_MODE_ALOOP} ccl_mode_t;
endpackage : ccl_pkg

// ---- ccl_slot_ctr.sv ----
/*
 * One direction's time-slot locator: counts bits and slots from
 * frame sync, compares with the active assignment, or with slot 0 when tsa_mode_i is low.
 * Assumes fs_start_i and bclk edges are pre-sampled strobes in clk_i domain.
 */
`timescale 1ns/10ps
module ccl_slot_ctr
    import ccl_pkg::*;
#(
    parameter int SLOTS = 64
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic bit_tick_i,
    input wire logic fs_start_i,
    input wire logic [5:0] slot_i,
    input wire logic tsa_mode_i,
    output logic in_slot_o,
    output logic [2:0] bit_idx_o
);
    logic [2:0] bit_reg;
    logic [5:0] slot_reg;
    logic run_reg;
    wire logic hit = run_reg && (tsa_mode_i ? (slot_reg == slot_i) : (slot_reg == 6'h00));

    // Bit and slot counting from frame start; stops after last slot
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            bit_reg <= 3'h0;
            slot_reg <= 6'h00;
            run_reg <= 1'b0;
        end else if (fs_start_i) begin // see [RL17]
            bit_reg <= 3'h0;
            slot_reg <= 6'h00;
            run_reg <= 1'b1;
        end else if (bit_tick_i && run_reg) begin
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
                slot_reg <= slot_reg + 6'h01;
                if (slot_reg == 6'(SLOTS - 1)) begin
                    run_reg <= 1'b0;
                end
            end
        end
    end

    assign in_slot_o = hit;
    assign bit_idx_o = bit_reg;

    AST_SLOT_ZERO_AT_FS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        fs_start_i |=> (slot_reg == 6'h00) && (bit_reg == 3'h0) && run_reg) // see [RL17]
        else $error("frame sync did not restart slot 0");
endmodule : ccl_slot_ctr

// ---- ccl_host_model.sv ----
/* Host model: serial control master and PCM frame source.
   Assumes one clk_i; every level changes on its falling edge. */
`timescale 1ns/10ps
module ccl_host_model (
    input wire logic clk_i,
    input wire logic co_i,
    input wire logic tx0_i,
    input wire logic tx0_oe_i,
    input wire logic tx1_oe_i,
    output logic cclk_o = 1'b0,
    output logic cs_n_o = 1'b1,
    output logic ci_o = 1'b0,
    output logic bclk_o = 1'b0,
    output logic fs_o = 1'b0,
    output logic rx0_o = 1'b0,
    output logic rx1_o = 1'b1
);
    ////////////////////////////////////////////////////////////
    // One 16-bit select; levels 4 cycles wide so the port sees them
    task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(negedge clk_i);
            ci_o = w[i];
            cclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
            rd = {rd[6:0], co_i};
            cclk_o = 1'b0;
            repeat (3) @(negedge clk_i);
        end
        ci_o = ~ci_o; // No stale bit once released
        cs_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask : xfer
    ////////////////////////////////////////////////////////////
    // 40-bit frame, sync on bit 0; slot 3 carries the word
    task automatic frame(input logic [7:0] rxw, output int first, output int n,
        output logic [7:0] txw, output int n1);
        first = -1;
        n = 0;
        n1 = 0;
        for (int b = 0; b < 40; b++) begin
            @(negedge clk_i);
            bclk_o = 1'b1;
            fs_o = (b == 0);
            rx1_o = (b >= 24 && b < 32) ? rxw[31 - b] : b[0];
            rx0_o = ~rx1_o;
            repeat (4) @(negedge clk_i);
            if (tx0_oe_i === 1'b1) begin
                first = (n == 0) ? b : first;
                txw = {txw[6:0], tx0_i};
                n++;
            end
            n1 += int'(tx1_oe_i === 1'b1);
            bclk_o = 1'b0;
            repeat (3) @(negedge clk_i);
        end
    endtask : frame
endmodule : ccl_host_model

// ---- test_codec_control_latch_timeslot.sv ----
/* Bench for the codec control block: register, latch and slot tests.
   Assumes the host model and the design files compile first. */
`timescale 1ns/10ps
`include "ccl_consts.svh"
module test_codec_control_latch_timeslot
    import ccl_pkg::*;
;
    logic clk_i = 1'b0;
    logic resetn_i, cclk_i, cs_n_i, ctl_data_i, ctl_data_o, ctl_data_oe_o, bclk_i, fs;
    logic rx_pcm_port0_i, rx_pcm_port1_i, tx_pcm_port0_o, tx_pcm_port0_oe_o, tx_pcm_port1_o;
    logic tx_pcm_port1_oe_o, rx_word_valid_o, analog_loop_o, tx_input_from_rx_o;
    logic rx_decode_run_o, powered_down_state_o, amp_off_o;
    logic [1:0] mclk_sel_o, law_o;
    logic [5:0] latch_pin_i, latch_pin_o, latch_pin_oe_o;
    logic [7:0] rx_codec_word_o, rx_seen, d, v, txw;
    int failures = 0;
    int n_compared = 0;
    int first, n, n1;
    wire co_line;
    // Readback line floats whenever the port lets go
    assign co_line = ctl_data_oe_o ? ctl_data_o : 1'bz;
    always #5 clk_i = ~clk_i;
    ccl_codec_ctrl uut (
        .clk_i, .resetn_i, .cclk_i, .cs_n_i, .ctl_data_i, .ctl_data_o, .ctl_data_oe_o,
        .bclk_i, .tx_frame_sync_i(fs), .rx_frame_sync_i(fs), .rx_pcm_port0_i, .rx_pcm_port1_i,
        .tx_pcm_port0_o, .tx_pcm_port0_oe_o, .tx_pcm_port1_o, .tx_pcm_port1_oe_o,
        .tx_codec_word_i(8'hB5), .rx_codec_word_o, .rx_word_valid_o, .analog_loop_o,
        .tx_input_from_rx_o, .rx_decode_run_o, .mclk_sel_o, .law_o, .powered_down_state_o,
        .amp_off_o, .latch_pin_i, .latch_pin_o, .latch_pin_oe_o
    );
    ccl_host_model host (
        .clk_i, .co_i(co_line), .tx0_i(tx_pcm_port0_o), .tx0_oe_i(tx_pcm_port0_oe_o),
        .tx1_oe_i(tx_pcm_port1_oe_o), .cclk_o(cclk_i), .cs_n_o(cs_n_i), .ci_o(ctl_data_i),
        .bclk_o(bclk_i), .fs_o(fs), .rx0_o(rx_pcm_port0_i), .rx1_o(rx_pcm_port1_i)
    );
    // Latest word handed over by the receive side
    always @(posedge clk_i)
        if (rx_word_valid_o === 1'b1) rx_seen <= rx_codec_word_o;
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Read keeps power up; the power bit rides on writes only
    task automatic wr(input logic p, input logic [3:0] a, input logic [7:0] w);
        logic [7:0] r;
        host.xfer({p, a, 3'b010, w}, r);
    endtask : wr
    task automatic rdr(input logic [3:0] a, output logic [7:0] r);
        host.xfer({1'b0, a, 3'b110, 8'h55}, r);
    endtask : rdr
    task automatic print_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    // Watchdog: the tests need about 34 us
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        resetn_i = 1'b0;
        latch_pin_i = 6'h10;
        repeat (6) @(negedge clk_i);
        resetn_i = 1'b1;
        check("latch oe", latch_pin_oe_o, 8'h00);
        rdr(`CCL_ADDR_CTRL, d);
        check("ctrl reset", d, `CCL_CTRL_RST);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            v = {i[1:0], i[1:0] ^ 2'b01, 1'b0, i[1:0], i[0]};
            wr(1'b0, `CCL_ADDR_CTRL, v); // Hybrid balance stays off
            rdr(`CCL_ADDR_CTRL, d);
            check("ctrl", d, v);
            check("mclk", mclk_sel_o, v[7:6]);
            check("law", law_o, i[1] ? {~i[0], i[0]} : 2'h0);
            check("aloop", {analog_loop_o, tx_input_from_rx_o}, {2{i == 1}});
            check("decode", rx_decode_run_o, 8'h01);
        end
        wr(1'b1, `CCL_ADDR_CTRL, 8'h09);
        check("amp off", {amp_off_o, powered_down_state_o}, 8'h03);
        wr(1'b1, `CCL_ADDR_CTRL, 8'h08);
        check("amp on", {amp_off_o, powered_down_state_o}, 8'h01);
        $display("test control done");
        wr(1'b0, `CCL_ADDR_LCONT, 8'hA4);
        wr(1'b0, `CCL_ADDR_LDIR, 8'hF0); // Latches 4, 5 used as inputs
        check("latch oe", latch_pin_oe_o, 8'h0F);
        check("latch out", latch_pin_o & latch_pin_oe_o, 8'h05);
        rdr(`CCL_ADDR_LCONT, d);
        check("latch read", d & 8'hFC, 8'hA8);
        $display("test latch done");
        wr(1'b0, `CCL_ADDR_CTRL, 8'h00);
        wr(1'b0, `CCL_ADDR_TXTS, 8'h83);
        wr(1'b0, `CCL_ADDR_RXTS, 8'hC3);
        host.frame(8'h3C, first, n, txw, n1);
        check("first frame", n[7:0], 8'h00);
        host.frame(8'h3C, first, n, txw, n1);
        check("slot start", first[7:0], 8'h18);
        check("tx bits", n[7:0], 8'h08);
        check("tx word", txw, 8'hB5);
        check("port1 idle", n1[7:0], 8'h00);
        check("rx word", rx_seen, 8'h3C);
        wr(1'b0, `CCL_ADDR_CTRL, 8'h04);
        host.frame(8'h3C, first, n, txw, n1);
        check("loop word", txw, 8'h3C);
        $display("test slot done");
        print_verdict();
    end
endmodule : test_codec_control_latch_timeslot
